/* shared/dod_pkg.sv */
// Purpose: shared constants and types of the opcode decode front
// Assumes: 16-bit instruction words, one word per valid strobe
// Notes: opcode patterns, field positions and cycle figures live here
package dod_pkg;

  // field positions in the first word
  localparam int TOP_NIB_MSB = 15;
  localparam int TOP_NIB_LSB = 12;
  localparam int SHIFT_HI_MSB = 11;
  localparam int SHIFT_HI_LSB = 8;
  localparam int SEL_MSB = 9;
  localparam int SEL_LSB = 8;
  localparam int STATE_MSB = 7;
  localparam int STATE_LSB = 4;
  localparam int MASK_MSB = 3;
  localparam int MASK_LSB = 0;

  // top nibbles
  localparam logic [3:0] NIB_ADD_SHIFT = 4'h2;
  localparam logic [3:0] NIB_COND_BRANCH = 4'he;

  // top bytes
  localparam logic [7:0] BYTE_ADD_CARRY = 8'h60;
  localparam logic [7:0] BYTE_ADD_HIGH = 8'h61;
  localparam logic [7:0] BYTE_ADD_LOW_NSE = 8'h62;
  localparam logic [7:0] BYTE_ADD_SHIFT_TEMP = 8'h63;
  localparam logic [7:0] BYTE_AND_MEM = 8'h6e;
  localparam logic [7:0] BYTE_AUX_ADD_IMM = 8'h78;
  localparam logic [7:0] BYTE_BRANCH = 8'h79;
  localparam logic [7:0] BYTE_BRANCH_AUX_NZ = 8'h7b;
  localparam logic [7:0] BYTE_ADD_SHORT_IMM = 8'hb8;
  localparam logic [7:0] BYTE_MISC = 8'hbe;
  localparam logic [7:0] BYTE_LONG_IMM = 8'hbf;

  // low bytes under the misc top byte
  localparam logic [7:0] LOW_MAGNITUDE = 8'h00;
  localparam logic [7:0] LOW_PROD_ADD = 8'h04;
  localparam logic [7:0] LOW_BRANCH_ACCUM = 8'h20;
  localparam logic [7:0] LOW_AND_LONG_16 = 8'h81;

  // third nibble under the long immediate top byte
  localparam logic [3:0] NIB3_ADD_LONG = 4'h9;
  localparam logic [3:0] NIB3_AND_LONG = 4'hb;

  // fixed shift of the and-long-by-16 form
  localparam logic [4:0] SHIFT_SIXTEEN = 5'h10;

  // condition select codes
  localparam logic [1:0] SEL_IO_LOW = 2'h0;
  localparam logic [1:0] SEL_TC_SET = 2'h1;
  localparam logic [1:0] SEL_TC_CLEAR = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  // execution cycles
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_MAGNITUDE = 5'h01,
    OP_ADD_SHIFT = 5'h02,
    OP_ADD_HIGH = 5'h03,
    OP_ADD_CARRY = 5'h04,
    OP_ADD_SHORT_IMM = 5'h05,
    OP_ADD_LONG_IMM = 5'h06,
    OP_ADD_LOW_NSE = 5'h07,
    OP_ADD_SHIFT_TEMP = 5'h08,
    OP_AUX_ADD_IMM = 5'h09,
    OP_AND_MEM = 5'h0a,
    OP_AND_LONG_SHIFT = 5'h0b,
    OP_AND_LONG_16 = 5'h0c,
    OP_PROD_ADD = 5'h0d,
    OP_BRANCH = 5'h0e,
    OP_BRANCH_ACCUM = 5'h0f,
    OP_BRANCH_AUX_NZ = 5'h10,
    OP_COND_BRANCH = 5'h11
  } dod_op_type;

  typedef enum logic [1:0] {
    ST_FIRST = 2'b00,
    ST_SECOND = 2'b01
  } dod_fsm_type;

  // live processor conditions, msb to lsb: zero, negative, overflow, carry
  typedef struct packed {
    logic accumZero;
    logic accumNeg;
    logic overflow;
    logic carry;
  } dod_cond_type;

  typedef struct packed {
    dod_op_type op;
    logic [4:0] shiftAmt;
    logic shiftByTemp;
    logic [7:0] lowByte;
    logic [15:0] secondWord;
    logic twoWord;
    logic isBranch;
    logic condMet;
    logic [2:0] cyclesTaken;
    logic [2:0] cyclesNotTaken;
  } dod_dec_type;

  localparam dod_dec_type DEC_RESET = '0;

endpackage

/* hdl/dod_cond_eval.sv */
// Purpose: evaluate the select bits and the mask/state condition field
// Assumes: all inputs on the core clock, io level already synchronised
// Notes: purely combinational
`timescale 1ns/100ps
module dod_cond_eval (
  // instruction fields
  input wire logic [1:0] selBits,
  input wire logic [3:0] maskBits,
  input wire logic [3:0] stateBits,
  // live conditions
  input wire dod_pkg::dod_cond_type live,
  input wire logic testControlFlag,
  input wire logic ioLow,
  // result
  output logic met
);
  import dod_pkg::*;

  logic selHit;
  logic [3:0] matchBits;

  always_comb begin
    case (selBits)
      SEL_IO_LOW: selHit = ioLow;
      SEL_TC_SET: selHit = testControlFlag;
      SEL_TC_CLEAR: selHit = ~testControlFlag;
      default: selHit = 1'b0;
    endcase
  end

  // a position counts when live state equals the required state
  assign matchBits = ~(stateBits ^ live);
  // mask gates the positions; any surviving bit meets the condition
  assign met = selHit | (|(maskBits & matchBits));

endmodule

/* hdl/dod_decode_front.sv */
// Functional notes
// - select 00 io low, 01 flag set, 10 clear, 11 none
// - condition field order zero, negative, overflow, carry
// - low four bits mask the tested conditions
// - bits seven to four give required states
// - mask ANDed with conditions; any bit meets
// - be00 decodes as accumulator magnitude
// - top nibble 2 add_low_no_sign_ext_op shifted memory operand
// - 61 add_low_no_sign_ext_op to high half, 60 add_low_no_sign_ext_op carry
// - b8 add_low_no_sign_ext_op eight-bit short immediate
// - bf9x two-word add of shifted constant
// - 62 add_low_no_sign_ext_op without sign extension; 63 temp shift
// - 78 add_low_no_sign_ext_op immediate to auxiliary register
// - 6e ands memory; bfbx two-word shifted and
// - be81 two-word and, constant shifted sixteen
// - be04 add_low_no_sign_ext_op product register to accumulator
// - be20 branches to accumulator address
// - 7b two-word branch on auxiliary nonzero
// - e0-e3 two-word conditional branch, select bits 9-8
// - e3 low byte picks accumulator/status test
// - e000 branches on io status low
//
// Purpose: decode the first group of the 16-bit instruction set
// Assumes: program memory strobes words with instrValid on sys_clk
// Notes: two-word forms hold their first word until the second arrives
`timescale 1ns/100ps
module dod_decode_front (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // instruction stream
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  // processor state
  input wire dod_pkg::dod_cond_type liveCond,
  input wire logic testControlFlag,
  input wire logic auxNonzero,
  // external pin, asynchronous, active low condition
  input wire logic ioStatusPin,
  // decode result
  output logic decValid,
  output dod_pkg::dod_dec_type decInfo,
  output logic decUnknown,
  output logic waitSecond
);
  import dod_pkg::*;

  typedef struct packed {
    dod_fsm_type fsm;
    logic [1:0] ioSync;
    dod_dec_type pend;
    logic decValid;
    dod_dec_type dec;
    logic unknown;
    logic waitSecond;
  } dod_state_type;

  dod_state_type state_r;
  dod_state_type state_nxt;

  logic condMet;
  logic ioLow;
  logic [7:0] topByte;
  logic [3:0] topNib;
  logic [3:0] nib3;
  dod_dec_type firstDec;
  logic firstKnown;

  // the pin is low-true; only the second sync stage is read
  assign ioLow = ~state_r.ioSync[1];
  assign topByte = instrWord[15:8];
  assign topNib = instrWord[TOP_NIB_MSB:TOP_NIB_LSB];
  assign nib3 = instrWord[7:4];

  dod_cond_eval u_cond (
    .selBits(instrWord[SEL_MSB:SEL_LSB]),
    .maskBits(instrWord[MASK_MSB:MASK_LSB]),
    .stateBits(instrWord[STATE_MSB:STATE_LSB]),
    .live(liveCond),
    .testControlFlag(testControlFlag),
    .ioLow(ioLow),
    .met(condMet)
  );

  // decode of a first word; conditions are sampled with this word
  always_comb begin
    firstDec = DEC_RESET;
    firstKnown = 1'b1;
    firstDec.lowByte = instrWord[7:0];
    firstDec.cyclesTaken = CYC_ONE;
    firstDec.cyclesNotTaken = CYC_ONE;
    if (topNib == NIB_ADD_SHIFT) begin
      firstDec.op = OP_ADD_SHIFT;
      firstDec.shiftAmt = {1'b0, instrWord[SHIFT_HI_MSB:SHIFT_HI_LSB]};
    end else if (topNib == NIB_COND_BRANCH && instrWord[11:10] == 2'b00) begin
      // select code in bits 9-8 (bits 11-10 zero), mask/state in the low byte
      firstDec.op = OP_COND_BRANCH;
      firstDec.twoWord = 1'b1;
      firstDec.isBranch = 1'b1;
      firstDec.condMet = condMet;
      firstDec.cyclesTaken = CYC_FOUR;
      if (instrWord[11:0] == 12'h000) begin
        firstDec.cyclesNotTaken = CYC_THREE;
      end else begin
        firstDec.cyclesNotTaken = CYC_TWO;
      end
    end else begin
      case (topByte)
        BYTE_ADD_CARRY: begin
          firstDec.op = OP_ADD_CARRY;
        end
        BYTE_ADD_HIGH: begin
          firstDec.op = OP_ADD_HIGH;
        end
        BYTE_ADD_LOW_NSE: begin
          firstDec.op = OP_ADD_LOW_NSE;
        end
        BYTE_ADD_SHIFT_TEMP: begin
          firstDec.op = OP_ADD_SHIFT_TEMP;
          firstDec.shiftByTemp = 1'b1;
        end
        BYTE_AND_MEM: begin
          firstDec.op = OP_AND_MEM;
        end
        BYTE_AUX_ADD_IMM: begin
          firstDec.op = OP_AUX_ADD_IMM;
        end
        BYTE_ADD_SHORT_IMM: begin
          firstDec.op = OP_ADD_SHORT_IMM;
        end
        BYTE_BRANCH: begin
          firstDec.op = OP_BRANCH;
          firstDec.twoWord = 1'b1;
          firstDec.isBranch = 1'b1;
          firstDec.condMet = 1'b1;
          firstDec.cyclesTaken = CYC_FOUR;
          firstDec.cyclesNotTaken = CYC_FOUR;
        end
        BYTE_BRANCH_AUX_NZ: begin
          firstDec.op = OP_BRANCH_AUX_NZ;
          firstDec.twoWord = 1'b1;
          firstDec.isBranch = 1'b1;
          firstDec.condMet = auxNonzero;
          firstDec.cyclesTaken = CYC_FOUR;
          firstDec.cyclesNotTaken = CYC_TWO;
        end
        BYTE_LONG_IMM: begin
          firstDec.shiftAmt = {1'b0, instrWord[3:0]};
          firstDec.twoWord = 1'b1;
          firstDec.cyclesTaken = CYC_TWO;
          firstDec.cyclesNotTaken = CYC_TWO;
          if (nib3 == NIB3_ADD_LONG) begin
            firstDec.op = OP_ADD_LONG_IMM;
          end else if (nib3 == NIB3_AND_LONG) begin
            firstDec.op = OP_AND_LONG_SHIFT;
          end else begin
            firstDec.op = OP_NONE;
            firstDec.twoWord = 1'b0;
            firstKnown = 1'b0;
          end
        end
        BYTE_MISC: begin
          case (instrWord[7:0])
            LOW_MAGNITUDE: begin
              firstDec.op = OP_MAGNITUDE;
            end
            LOW_PROD_ADD: begin
              firstDec.op = OP_PROD_ADD;
            end
            LOW_BRANCH_ACCUM: begin
              firstDec.op = OP_BRANCH_ACCUM;
              firstDec.isBranch = 1'b1;
              firstDec.condMet = 1'b1;
              firstDec.cyclesTaken = CYC_FOUR;
              firstDec.cyclesNotTaken = CYC_FOUR;
            end
            LOW_AND_LONG_16: begin
              firstDec.op = OP_AND_LONG_16;
              firstDec.shiftAmt = SHIFT_SIXTEEN;
              firstDec.twoWord = 1'b1;
              firstDec.cyclesTaken = CYC_TWO;
              firstDec.cyclesNotTaken = CYC_TWO;
            end
            default: begin
              firstDec.op = OP_NONE;
              firstKnown = 1'b0;
            end
          endcase
        end
        default: begin
          firstDec.op = OP_NONE;
          firstKnown = 1'b0;
        end
      endcase
    end
  end

  // sequencing of one- and two-word forms
  always_comb begin
    state_nxt = state_r;
    state_nxt.ioSync = {state_r.ioSync[0], ioStatusPin};
    state_nxt.decValid = 1'b0;
    case (state_r.fsm)
      ST_FIRST: begin
        if (instrValid) begin
          if (firstDec.twoWord) begin
            // hold the first word's decode; nothing is announced yet
            state_nxt.pend = firstDec;
            state_nxt.fsm = ST_SECOND;
            state_nxt.waitSecond = 1'b1;
          end else begin
            state_nxt.dec = firstDec;
            state_nxt.unknown = ~firstKnown;
            state_nxt.decValid = 1'b1;
          end
        end
      end
      ST_SECOND: begin
        if (instrValid) begin
          // second word is the constant or the branch target
          state_nxt.dec = state_r.pend;
          state_nxt.dec.secondWord = instrWord;
          state_nxt.unknown = 1'b0;
          state_nxt.decValid = 1'b1;
          state_nxt.fsm = ST_FIRST;
          state_nxt.waitSecond = 1'b0;
        end
      end
      default: begin
        state_nxt.fsm = ST_FIRST;
        state_nxt.waitSecond = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r.fsm <= ST_FIRST;
      state_r.ioSync <= 2'h3;
      state_r.pend <= DEC_RESET;
      state_r.decValid <= 1'b0;
      state_r.dec <= DEC_RESET;
      state_r.unknown <= 1'b0;
      state_r.waitSecond <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign decValid = state_r.decValid;
  assign decInfo = state_r.dec;
  assign decUnknown = state_r.unknown;
  assign waitSecond = state_r.waitSecond;

endmodule

/* bench/dod_decode_front_chk.sv */
// Purpose: port-level assertions for the opcode decode front
// Assumes: single clock, synchronous active-low reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/100ps
module dod_decode_front_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // instruction stream
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  // processor state
  input wire dod_pkg::dod_cond_type liveCond,
  input wire logic testControlFlag,
  input wire logic auxNonzero,
  input wire logic ioStatusPin,
  // decode result
  input wire logic decValid,
  input wire dod_pkg::dod_dec_type decInfo,
  input wire logic decUnknown,
  input wire logic waitSecond
);
  import dod_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // a word taken while no pair is open starts a new instruction
  logic takeFirst;
  assign takeFirst = instrValid && !waitSecond;

  a_magnitude_decode: assert property (
    takeFirst && instrWord == 16'hbe00 |=> decValid && decInfo.op == OP_MAGNITUDE)
    else $error("magnitude word misdecoded");
  a_add_shift_field: assert property (
    takeFirst && instrWord[15:12] == NIB_ADD_SHIFT |=> decValid && decInfo.op == OP_ADD_SHIFT
    && decInfo.shiftAmt == {1'b0, $past(instrWord[11:8])}) else $error("add shift misdecoded");
  a_short_imm_byte: assert property (
    takeFirst && instrWord[15:8] == BYTE_ADD_SHORT_IMM |=> decInfo.op == OP_ADD_SHORT_IMM
    && decInfo.lowByte == $past(instrWord[7:0])) else $error("short immediate misdecoded");
  a_long_imm_wait: assert property (
    takeFirst && instrWord[15:4] == 12'hbf9 |=> waitSecond && !decValid)
    else $error("long immediate did not wait");
  a_cond_first_word: assert property (
    takeFirst && instrWord[15:10] == 6'h38 |=> $rose(waitSecond))
    else $error("conditional branch not two words");
  a_second_word_pair: assert property (
    waitSecond && instrValid |=> decValid && !waitSecond && decInfo.twoWord
    && decInfo.secondWord == $past(instrWord)) else $error("second word not paired");
  a_cond_cycles: assert property (
    decValid && decInfo.op == OP_COND_BRANCH |-> decInfo.cyclesTaken == CYC_FOUR
    && decInfo.isBranch) else $error("conditional branch cycles wrong");
  a_and_sixteen: assert property (
    decValid && decInfo.op == OP_AND_LONG_16 |-> decInfo.shiftAmt == SHIFT_SIXTEEN)
    else $error("and by sixteen shift wrong");
  a_branch_accum: assert property (
    takeFirst && instrWord == 16'hbe20 |=> decInfo.op == OP_BRANCH_ACCUM && decInfo.condMet)
    else $error("accumulator branch misdecoded");

  c_cond_met: cover property (decValid && decInfo.op == OP_COND_BRANCH && decInfo.condMet);
  c_unknown: cover property (decValid && decUnknown);
  c_pair: cover property (waitSecond && instrValid ##1 decValid);
endmodule

bind dod_decode_front dod_decode_front_chk dod_decode_front_chk_i (.sys_clk(sys_clk),
  .nrst(nrst), .instrValid(instrValid), .instrWord(instrWord), .liveCond(liveCond),
  .testControlFlag(testControlFlag), .auxNonzero(auxNonzero), .ioStatusPin(ioStatusPin),
  .decValid(decValid), .decInfo(decInfo), .decUnknown(decUnknown), .waitSecond(waitSecond));

/* bench/dod_prog_mem.sv */
// Purpose: program memory model streaming instruction words
// Assumes: words preloaded by the bench, read in address order
// Notes: address survives reset so a stream can resume after it
`timescale 1ns/100ps
module dod_prog_mem (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // fetch request
  input wire logic fetch,
  // word stream
  output logic instrValid,
  output logic [15:0] instrWord
);
  logic [15:0] mem [0:63];
  logic [5:0] pc_r = 6'h00;
  initial instrWord = 16'h0000;
  initial instrValid = 1'b0;
  always @(posedge sys_clk) begin
    instrValid <= nrst && fetch;
    if (nrst && fetch) begin
      instrWord <= mem[pc_r];
      pc_r <= pc_r + 6'h01;
    end else begin
      // idle bus inverts the held word every cycle
      instrWord <= ~instrWord;
    end
  end
endmodule

/* bench/test_dod_decode_front.sv */
// Purpose: self-checking bench for the opcode decode front
// Assumes: decode answers one cycle after the last word is taken
// Notes: table stream runs back to back, then hand tests
`timescale 1ns/100ps
module test_dod_decode_front;
  import dod_pkg::*;
  typedef struct packed {
    logic [15:0] w1;
    logic [15:0] w2;
    dod_op_type op;
    logic [4:0] sh;
    logic [2:0] ct;
    logic [2:0] cn;
  } dod_row_type;
  localparam int NROWS = 22;
  localparam dod_row_type ROWS [NROWS] = '{
    '{16'hbe00, 16'h0000, OP_MAGNITUDE, 5'h00, 3'h1, 3'h1},
    '{16'h2312, 16'h0000, OP_ADD_SHIFT, 5'h03, 3'h1, 3'h1},
    '{16'h61aa, 16'h0000, OP_ADD_HIGH, 5'h00, 3'h1, 3'h1},
    '{16'h60aa, 16'h0000, OP_ADD_CARRY, 5'h00, 3'h1, 3'h1},
    '{16'hb8ff, 16'h0000, OP_ADD_SHORT_IMM, 5'h00, 3'h1, 3'h1},
    '{16'hbf95, 16'h1234, OP_ADD_LONG_IMM, 5'h05, 3'h2, 3'h2},
    '{16'h62aa, 16'h0000, OP_ADD_LOW_NSE, 5'h00, 3'h1, 3'h1},
    '{16'h63aa, 16'h0000, OP_ADD_SHIFT_TEMP, 5'h00, 3'h1, 3'h1},
    '{16'h7805, 16'h0000, OP_AUX_ADD_IMM, 5'h00, 3'h1, 3'h1},
    '{16'h6eaa, 16'h0000, OP_AND_MEM, 5'h00, 3'h1, 3'h1},
    '{16'hbfbf, 16'hffff, OP_AND_LONG_SHIFT, 5'h0f, 3'h2, 3'h2},
    '{16'hbe81, 16'h00ff, OP_AND_LONG_16, 5'h10, 3'h2, 3'h2},
    '{16'hbe04, 16'h0000, OP_PROD_ADD, 5'h00, 3'h1, 3'h1},
    '{16'hbe20, 16'h0000, OP_BRANCH_ACCUM, 5'h00, 3'h4, 3'h4},
    '{16'h7b00, 16'h0100, OP_BRANCH_AUX_NZ, 5'h00, 3'h4, 3'h2},
    '{16'he100, 16'h0200, OP_COND_BRANCH, 5'h00, 3'h4, 3'h2},
    '{16'he200, 16'h0300, OP_COND_BRANCH, 5'h00, 3'h4, 3'h2},
    '{16'he000, 16'h0400, OP_COND_BRANCH, 5'h00, 3'h4, 3'h3},
    '{16'he344, 16'h0500, OP_COND_BRANCH, 5'h00, 3'h4, 3'h2},
    '{16'he301, 16'h0600, OP_COND_BRANCH, 5'h00, 3'h4, 3'h2},
    '{16'h7900, 16'h0700, OP_BRANCH, 5'h00, 3'h4, 3'h4},
    '{16'hbf00, 16'h0000, OP_NONE, 5'h00, 3'h0, 3'h0}};
  logic sys_clk = 1'b0;
  logic nrst, fetch, instrValid, testControlFlag, auxNonzero, ioStatusPin;
  logic decValid, decUnknown, waitSecond, tblOn;
  logic [15:0] instrWord;
  dod_cond_type liveCond;
  dod_dec_type decInfo;
  dod_row_type r;
  int k, n, errCount, nTests;

  always #20 sys_clk = ~sys_clk;

  dod_prog_mem dod_prog_mem_i (.sys_clk(sys_clk), .nrst(nrst), .fetch(fetch),
    .instrValid(instrValid), .instrWord(instrWord));
  dod_decode_front dod_decode_front_i (.sys_clk(sys_clk), .nrst(nrst),
    .instrValid(instrValid), .instrWord(instrWord), .liveCond(liveCond),
    .testControlFlag(testControlFlag), .auxNonzero(auxNonzero), .ioStatusPin(ioStatusPin),
    .decValid(decValid), .decInfo(decInfo), .decUnknown(decUnknown), .waitSecond(waitSecond));

  function automatic logic twoW(input dod_op_type o);
    twoW = o inside {OP_ADD_LONG_IMM, OP_AND_LONG_SHIFT, OP_AND_LONG_16, OP_BRANCH,
      OP_BRANCH_AUX_NZ, OP_COND_BRANCH};
  endfunction

  // only meaningful for branch rows
  function automatic logic expMet(input dod_row_type e);
    logic [1:0] s;
    s = e.w1[9:8];
    if (e.op == OP_BRANCH_AUX_NZ) expMet = auxNonzero;
    else if (e.op != OP_COND_BRANCH) expMet = 1'b1;
    else expMet = (|(e.w1[3:0] & ~(e.w1[7:4] ^ liveCond))) || (s == 2'h0 && !ioStatusPin)
      || (s == 2'h1 && testControlFlag) || (s == 2'h2 && !testControlFlag);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic feed(input int cnt);
    fetch <= 1'b1;
    repeat (cnt) @(posedge sys_clk);
    fetch <= 1'b0;
  endtask

  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    if (tblOn && nrst && decValid) begin
      r = ROWS[k];
      chk(16'(decInfo.op), 16'(r.op));
      chk(16'(decInfo.shiftAmt), 16'(r.sh));
      chk(16'(decUnknown), 16'(r.op == OP_NONE));
      chk(16'(decInfo.twoWord), 16'(twoW(r.op)));
      chk(16'(decInfo.lowByte), 16'(r.w1[7:0]));
      chk(16'(decInfo.shiftByTemp), 16'(r.op == OP_ADD_SHIFT_TEMP));
      chk(16'(decInfo.isBranch), 16'(r.ct == 3'h4));
      if (twoW(r.op)) chk(decInfo.secondWord, r.w2);
      if (r.op != OP_NONE) chk(16'({decInfo.cyclesTaken, decInfo.cyclesNotTaken}), 16'({r.ct, r.cn}));
      if (r.ct == 3'h4) chk(16'(decInfo.condMet), 16'(expMet(r)));
      k = k + 1;
    end
  end

  initial begin
    repeat (400) @(posedge sys_clk);
    errCount++;
    wrapUp;
  end

  initial begin
    nrst = 1'b0; fetch = 1'b0; tblOn = 1'b1; k = 0; n = 0; errCount = 0; nTests = 0;
    liveCond = 4'h5; testControlFlag = 1'b1; auxNonzero = 1'b1; ioStatusPin = 1'b0;
    for (int i = 0; i < NROWS; i++) begin
      dod_prog_mem_i.mem[n] = ROWS[i].w1;
      n++;
      if (twoW(ROWS[i].op)) begin
        dod_prog_mem_i.mem[n] = ROWS[i].w2;
        n++;
      end
    end
    dod_prog_mem_i.mem[n] = 16'he301;
    dod_prog_mem_i.mem[n + 1] = 16'h0042;
    dod_prog_mem_i.mem[n + 2] = 16'hbe81;
    dod_prog_mem_i.mem[n + 3] = 16'hbe00;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    feed(n);
    repeat (6) @(posedge sys_clk);
    chk(16'(k), 16'(NROWS));
    tblOn = 1'b0;
    $display("table test done");
    // conditions must be those seen with the first word
    liveCond <= 4'h4;
    feed(1);
    @(posedge sys_clk);
    liveCond <= 4'h5;
    #1 chk(16'(waitSecond), 16'h0001);
    @(posedge sys_clk);
    feed(1);
    @(posedge sys_clk);
    #1 chk(16'(decValid), 16'h0001);
    chk(16'(decInfo.condMet), 16'h0001);
    chk(decInfo.secondWord, 16'h0042);
    $display("pair test done");
    @(posedge sys_clk);
    feed(1);
    @(posedge sys_clk);
    nrst <= 1'b0;
    #1 chk(16'(waitSecond), 16'h0001);
    @(posedge sys_clk);
    nrst <= 1'b1;
    #1 chk(16'({waitSecond, decValid}), 16'h0000);
    @(posedge sys_clk);
    feed(1);
    @(posedge sys_clk);
    #1 chk(16'({decValid, decInfo.op}), 16'({1'b1, OP_MAGNITUDE}));
    $display("reset test done");
    wrapUp;
  end
endmodule
